// >>> bench/dmi_dram_model.sv
// Behavioural DRAM partner: latches mode sets and times each init step
`timescale 1ns/1ps
module dmi_dram_model #(
   parameter int MRD = 4,
   parameter int MOD = 12
) (
   input  wire logic              ref_clk,
   input  wire logic              memClk,
   input  wire logic              memRstN,
   input  wire logic              memCke,
   input  wire logic              term_ctrl_in,
   input  wire dmi_pkg::dmi_cmd_s memCmd,
   output logic [3:0][12:0]       mr,
   output logic [7:0]             order,
   output logic [2:0]             nMrs,
   output logic [15:0]            rstLen,
   output logic [15:0]            exitLen,
   output logic [15:0]            xprLen,
   output logic [15:0]            zqAge,
   output logic [7:0]             bad,
   output logic                   dllRst,
   output logic                   termHiZ,
   output logic [3:0]             colLat
);
   logic [15:0] cnt_ff;
   logic [15:0] gap_ff;
   logic [7:0]  clkRise_ff;
   logic        rstQ_ff;
   logic        ckeQ_ff;
   logic        clkQ_ff;
   logic        ckeSeen_ff;
   logic        termQ_ff;
   logic [3:0]  cmd;
   // Strobe nibble of the command bus
   assign cmd = {memCmd.csN, memCmd.rasN, memCmd.casN, memCmd.weN};
   // Termination floats until cke is first seen high after reset
   assign termHiZ = !memRstN || !ckeSeen_ff;
   assign colLat = {mr[0][6:4], mr[0][2]};
   // Commands last one fast cycle, so everything is sampled at the fast clock
   always_ff @(posedge ref_clk)
   begin
      rstQ_ff <= memRstN;
      ckeQ_ff <= memCke;
      clkQ_ff <= memClk;
      cnt_ff <= cnt_ff + 16'h0001;
      gap_ff <= gap_ff + 16'h0001;
      if (zqAge != 16'hFFFF) zqAge <= zqAge + 16'h0001;
      if (memClk && !clkQ_ff && clkRise_ff != 8'hFF) clkRise_ff <= clkRise_ff + 8'h01;
      if (memRstN && !rstQ_ff)
      begin
         rstLen <= cnt_ff;
         cnt_ff <= 16'h0000;
         clkRise_ff <= 8'h00;
         if (ckeQ_ff || memCke) bad <= bad + 8'h01;
      end
      if (memCke && !ckeQ_ff)
      begin
         exitLen <= cnt_ff;
         cnt_ff <= 16'h0000;
         ckeSeen_ff <= 1'b1;
         termQ_ff <= term_ctrl_in;
         if (clkRise_ff < 8'h05) bad <= bad + 8'h01;
      end
      if (ckeSeen_ff && memCke && term_ctrl_in != termQ_ff) bad <= bad + 8'h01;
      if (memCke && cmd != dmi_pkg::CMD_DES && cmd != dmi_pkg::CMD_NOP)
      begin
         gap_ff <= 16'h0001;
         if (cmd == dmi_pkg::CMD_MRS && !memCmd.bank[2])
         begin
            if (nMrs == 3'h0) xprLen <= cnt_ff;
            else if (gap_ff < 16'(MRD)) bad <= bad + 8'h01;
            mr[memCmd.bank[1:0]] <= memCmd.addr;
            if (memCmd.bank[1:0] == 2'h0) dllRst <= memCmd.addr[8];
            if (memCmd.bank[1:0] == 2'h0) mr[0][8] <= 1'b0;
            order <= {order[5:0], memCmd.bank[1:0]};
            nMrs <= nMrs + 3'h1;
         end
         else if (cmd == dmi_pkg::CMD_ZQL && memCmd.addr[10] && gap_ff >= 16'(MOD))
            zqAge <= 16'h0000;
         else
            bad <= bad + 8'h01;
      end
      // Reset wipes the logs; the mode registers keep their last contents
      if (!memRstN)
      begin
         if (rstQ_ff !== 1'b0) cnt_ff <= 16'h0001;
         nMrs <= 3'h0;
         order <= 8'h00;
         ckeSeen_ff <= 1'b0;
         zqAge <= 16'h0000;
         gap_ff <= 16'h0000;
         clkRise_ff <= 8'h00;
         dllRst <= 1'b0;
         bad <= 8'h00;
      end
   end
endmodule

// >>> bench/tb_top.sv
// Top bench: drives the controller over APB against a behavioural DRAM
`timescale 1ns/1ps
module tb_top;
   localparam int PWR = 20;
   localparam int EXIT = 20;
   localparam int CAL = 16;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} dmi_row_s;
   logic              ref_clk = 1'b0;
   logic              arst_n = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0000_0000;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              memClk;
   logic              memRstN;
   logic              memCke;
   logic              term_ctrl_in;
   dmi_pkg::dmi_cmd_s memCmd;
   logic [3:0][12:0]  mr;
   logic [7:0]        order;
   logic [2:0]        nMrs;
   logic [15:0]       rstLen;
   logic [15:0]       exitLen;
   logic [15:0]       xprLen;
   logic [15:0]       zqAge;
   logic [7:0]        bad;
   logic              dllRst;
   logic [31:0]       rd;
   logic              er;
   int                errCount = 0;
   int                numChecks = 0;
   dmi_row_s          rows [12] = '{
      '{1'b1, 8'h08, 32'h0000_1AB4, 32'h0000_0000, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0000_1A34, 1'b0},
      '{1'b1, 8'h0C, 32'h0000_0047, 32'h0000_0000, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h0000_0047, 1'b0},
      '{1'b1, 8'h10, 32'h0000_0018, 32'h0000_0000, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h0000_0018, 1'b0},
      '{1'b1, 8'h14, 32'h0000_0004, 32'h0000_0000, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0000_0004, 1'b0},
      '{1'b1, 8'h18, 32'h0000_00AB, 32'h0000_0000, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0000_00AB, 1'b0},
      '{1'b0, 8'h1C, 32'h0000_0000, 32'h0000_0000, 1'b1}, '{1'b1, 8'h20, 32'h5, 32'h0000_0000, 1'b1}};

   // Shortened waits keep the run to a few hundred cycles
   dmi_init_ctrl #(.PWR_RST_CYCLES(PWR), .RST_EXIT_CYCLES(EXIT), .DLLK_CYCLES(CAL),
                   .ZQINIT_CYCLES(CAL)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .memClk(memClk), .memRstN(memRstN),
      .memCke(memCke), .term_ctrl_in(term_ctrl_in), .memCmd(memCmd));
   dmi_dram_model #(.MRD(4), .MOD(12)) u_mem (.ref_clk(ref_clk), .memClk(memClk),
      .memRstN(memRstN), .memCke(memCke), .term_ctrl_in(term_ctrl_in), .memCmd(memCmd),
      .mr(mr), .order(order), .nMrs(nMrs), .rstLen(rstLen), .exitLen(exitLen),
      .xprLen(xprLen), .zqAge(zqAge), .bad(bad), .dllRst(dllRst), .termHiZ(), .colLat());

   // 25 MHz reference clock
   always #20 ref_clk = ~ref_clk;

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp)
      begin
         errCount++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; waits on pready rather than assuming zero wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 200);
      if (n >= 200) errCount++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Start a sequence, optionally poke MR3 while busy, then poll for done
   task automatic runSeq(input logic [31:0] ctrl, input logic poke);
      int n;
      apb(1'b1, dmi_pkg::OFF_CTRL, ctrl);
      if (poke) apb(1'b1, dmi_pkg::OFF_MR3, 32'h0000_000F);
      repeat (4) @(posedge ref_clk);
      n = 0;
      do
      begin
         apb(1'b0, dmi_pkg::OFF_STATUS, 32'h0);
         n++;
      end
      while (rd[1] !== 1'b1 && n < 500);
      chk("done", 32'(rd[1]), 32'h1);
   endtask

   task automatic finishTest;
      $display("checks %0d errors %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Long enough for three full sequences with slack
   initial
   begin
      #(40 * 30000);
      errCount++;
      finishTest();
   end

   initial
   begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      // Reset state: device held in reset with clock-enable low
      apb(1'b0, dmi_pkg::OFF_MR0, 32'h0);
      chk("mr0Rst", rd, 32'(dmi_pkg::MR0_RST));
      apb(1'b0, dmi_pkg::OFF_STATUS, 32'h0);
      chk("rstCke", 32'(rd[7:6]), 32'h0);
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         chk("err", 32'(er), 32'(rows[i].e));
         if (!rows[i].wr) chk("rdata", rd, rows[i].q);
      end
      // Cold start, MR3 poke while busy must be dropped
      runSeq(32'h0000_0005, 1'b1);
      chk("rstLen", 32'(rstLen >= PWR), 32'h1);
      chk("exitLen", 32'(exitLen >= EXIT), 32'h1);
      chk("xprLen", 32'(xprLen >= 16'(dmi_pkg::XPR_TCK_MIN * 8)), 32'h1);
      chk("order", 32'(order), 32'h0000_00B4);
      chk("nMrs", 32'(nMrs), 32'h4);
      chk("mr0", 32'(mr[0]), 32'h0000_1A34);
      chk("mr1", 32'(mr[1]), 32'h0000_0046);
      chk("mr2", 32'(mr[2]), 32'h0000_0018);
      chk("mr3", 32'(mr[3]), 32'h0000_0004);
      chk("dllRst", 32'(dllRst), 32'h1);
      chk("zqAge", 32'(zqAge >= CAL), 32'h1);
      chk("bad", 32'(bad), 32'h0);
      chk("cke", 32'(memCke), 32'h1);
      // Warm reset with termination held high
      runSeq(32'h0000_0003, 1'b0);
      chk("warmLen", 32'(rstLen >= 3 && rstLen < PWR), 32'h1);
      chk("order2", 32'(order), 32'h0000_00B4);
      chk("bad2", 32'(bad), 32'h0);
      chk("term", 32'(term_ctrl_in), 32'h1);
      // Rewrite one register in idle, without another reset
      apb(1'b1, dmi_pkg::OFF_MR2, 32'h0000_0008);
      runSeq(32'h0000_0008, 1'b0);
      chk("remode", 32'(mr[2]), 32'h0000_0008);
      chk("noRst", 32'(memRstN), 32'h1);
      finishTest();
   end
endmodule

// >>> logic/dmi_init_ctrl.sv
// Host-side controller that resets and initializes the DRAM and sets its mode registers
`timescale 1ns/1ps
module dmi_init_ctrl #(
   parameter int PWR_RST_CYCLES  = dmi_pkg::PWR_RST_CYC,
   parameter int RST_EXIT_CYCLES = dmi_pkg::RST_EXIT_CYC,
   parameter int XS_CYCLES       = 8,
   parameter int MRD_CYCLES      = 4,
   parameter int MOD_CYCLES      = 12,
   parameter int DLLK_CYCLES     = 512,
   parameter int ZQINIT_CYCLES   = 512,
   parameter int CLK_DIV         = 4
) (
   input  wire logic               ref_clk,
   input  wire logic               arst_n,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic                    memClk,
   output logic                    memRstN,
   output logic                    memCke,
   output logic                    term_ctrl_in,
   output dmi_pkg::dmi_cmd_s       memCmd // R22
);
   localparam int CW = 20;
   localparam int MAXC = (1 << CW) - 1;

   dmi_pkg::dmi_state_e stateFf;
   logic [CW-1:0]       cntFf;
   logic [1:0]          mrIdxFf;
   logic [12:0]         mr0Ff, mr1Ff, mr2Ff, mr3Ff;
   logic [7:0]          waitFf;
   logic                termLvlFf, coldFf, startFf, remodeFf, doneFf, errFf;
   logic [7:0]          divCntFf;
   logic                clkFf, clkRiseFf;
   logic [3:0]          tickCntFf;
   logic                ckeHiSeen;

   // Clamp helper for counter loads
   function automatic logic [CW-1:0] clampc(input int v);
      int t;
      t = (v < 1) ? 1 : ((v > MAXC) ? MAXC : v);
      return t[CW-1:0];
   endfunction

   localparam int XPR_CYC = (XS_CYCLES > dmi_pkg::XPR_TCK_MIN * CLK_DIV * 2) ?
                            XS_CYCLES : dmi_pkg::XPR_TCK_MIN * CLK_DIV * 2;
   localparam int CKSTB_CYC = (dmi_pkg::CLK_STB_NS_CYC > dmi_pkg::CLK_STB_TCK * CLK_DIV * 2) ?
                              dmi_pkg::CLK_STB_NS_CYC : dmi_pkg::CLK_STB_TCK * CLK_DIV * 2;
   localparam int CALW_CYC = (DLLK_CYCLES > ZQINIT_CYCLES) ? DLLK_CYCLES : ZQINIT_CYCLES;

   // Memory clock divider; runs whenever out of reset so it is stable before CKE
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         divCntFf  <= 8'h00;
         clkFf     <= 1'b0;
         clkRiseFf <= 1'b0;
      end
      else if (divCntFf == 8'(CLK_DIV - 1))
      begin
         divCntFf  <= 8'h00;
         clkFf     <= ~clkFf;
         clkRiseFf <= ~clkFf;
      end
      else
      begin
         divCntFf  <= divCntFf + 8'h01;
         clkRiseFf <= 1'b0;
      end
   end
   assign memClk = clkFf;

   // APB slave: zero wait states, unmapped reads give zero with an error
   assign pready = 1'b1;
   always_comb
   begin
      pslverr = 1'b0;
      if (paddr == dmi_pkg::OFF_CTRL || paddr == dmi_pkg::OFF_STATUS ||
          paddr == dmi_pkg::OFF_MR0 || paddr == dmi_pkg::OFF_MR1 ||
          paddr == dmi_pkg::OFF_MR2 || paddr == dmi_pkg::OFF_MR3 ||
          paddr == dmi_pkg::OFF_WAIT)
         pslverr = 1'b0;
      else
         pslverr = psel & penable;
   end

   always_comb
   begin
      prdata = 32'h0000_0000;
      if (paddr == dmi_pkg::OFF_CTRL)
         prdata = {28'h000_0000, remodeFf, coldFf, termLvlFf, startFf};
      else if (paddr == dmi_pkg::OFF_STATUS)
         prdata = {23'h00_0000, errFf, memCke, memRstN, stateFf, doneFf, 1'b0};
      else if (paddr == dmi_pkg::OFF_MR0)
         prdata = {19'h0_0000, mr0Ff};
      else if (paddr == dmi_pkg::OFF_MR1)
         prdata = {19'h0_0000, mr1Ff};
      else if (paddr == dmi_pkg::OFF_MR2)
         prdata = {19'h0_0000, mr2Ff};
      else if (paddr == dmi_pkg::OFF_MR3)
         prdata = {19'h0_0000, mr3Ff};
      else if (paddr == dmi_pkg::OFF_WAIT)
         prdata = {24'h00_0000, waitFf};
      else
         prdata = 32'h0000_0000;
   end

   wire logic apbWr = psel & penable & pwrite;
   wire logic busy  = (stateFf != dmi_pkg::ST_IDLE) && (stateFf != dmi_pkg::ST_READY);

   // Writable registers; mode images locked while a sequence runs
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mr0Ff     <= dmi_pkg::MR0_RST;
         mr1Ff     <= dmi_pkg::MR1_RST;
         mr2Ff     <= dmi_pkg::MR2_RST;
         mr3Ff     <= dmi_pkg::MR3_RST;
         waitFf    <= dmi_pkg::WAIT_RST;
         termLvlFf <= 1'b0;
         coldFf    <= 1'b1;
      end
      else if (apbWr && !busy)
      begin
         if (paddr == dmi_pkg::OFF_CTRL)
         begin
            termLvlFf <= pwdata[dmi_pkg::CTRL_TERMLVL];
            coldFf    <= pwdata[dmi_pkg::CTRL_COLD];
         end
         // Test-mode bit forced to zero; DLL-reset bit is added at issue time
         else if (paddr == dmi_pkg::OFF_MR0)
            mr0Ff <= pwdata[12:0] & ~(13'h0_001 << dmi_pkg::MR0_TEST); // R19 R21
         else if (paddr == dmi_pkg::OFF_MR1)
            mr1Ff <= pwdata[12:0];
         else if (paddr == dmi_pkg::OFF_MR2)
            mr2Ff <= pwdata[12:0];
         else if (paddr == dmi_pkg::OFF_MR3)
            mr3Ff <= pwdata[12:0];
         else if (paddr == dmi_pkg::OFF_WAIT)
            waitFf <= pwdata[7:0];
      end
   end

   // Start and remode requests: set by software; start cleared when taken, remode after the last mode set or in idle or reset
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         startFf  <= 1'b0;
         remodeFf <= 1'b0;
      end
      else
      begin
         if (apbWr && paddr == dmi_pkg::OFF_CTRL && pwdata[dmi_pkg::CTRL_START])
            startFf <= 1'b1;
         else if (stateFf == dmi_pkg::ST_IDLE || stateFf == dmi_pkg::ST_READY)
            startFf <= 1'b0;
         if (apbWr && !busy && paddr == dmi_pkg::OFF_CTRL && pwdata[dmi_pkg::CTRL_REMODE])
            remodeFf <= 1'b1;
         else if (stateFf == dmi_pkg::ST_IDLE || stateFf == dmi_pkg::ST_RST ||
                  (stateFf == dmi_pkg::ST_MRSGAP && cntFf == '0 && mrIdxFf == 2'd3))
            remodeFf <= 1'b0;
      end
   end

   // Mode set word for the current index; order 2,3,1,0
   dmi_pkg::dmi_cmd_s mrsCmd;
   always_comb
   begin
      mrsCmd = '{csN: 1'b0, rasN: 1'b0, casN: 1'b0, weN: 1'b0, bank: 3'h0, addr: 13'h0_000};
      case (mrIdxFf) // R9 R10 R16
         2'd0:
         begin
            mrsCmd.bank = dmi_pkg::BA_MR2;
            mrsCmd.addr = mr2Ff;
         end
         2'd1:
         begin
            mrsCmd.bank = dmi_pkg::BA_MR3;
            mrsCmd.addr = mr3Ff;
         end
         2'd2:
         begin
            mrsCmd.bank = dmi_pkg::BA_MR1;
            mrsCmd.addr = mr1Ff & ~(13'h0_001 << dmi_pkg::MR1_DLL_DIS); // R11
         end
         default:
         begin
            mrsCmd.bank = dmi_pkg::BA_MR0;
            mrsCmd.addr = mr0Ff | (13'h0_001 << dmi_pkg::MR0_DLL_RST); // R11
         end
      endcase
   end

   // Sequencer: every wait is a down-counter; warm reset and CKE setup load fixed package values, the rest parameters
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stateFf <= dmi_pkg::ST_IDLE;
         cntFf   <= '0;
         mrIdxFf <= 2'd0;
         doneFf  <= 1'b0;
         errFf   <= 1'b0;
         memRstN <= 1'b0;
         memCke  <= 1'b0;
         memCmd  <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, bank: 3'h0, addr: 13'h0_000};
      end
      else
      begin
         memCmd <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1, bank: 3'h0, addr: 13'h0_000};
         if (cntFf != '0)
            cntFf <= cntFf - 1'b1; // R24
         case (stateFf)
            dmi_pkg::ST_IDLE:
               if (startFf)
               begin
                  stateFf <= dmi_pkg::ST_RST;
                  memRstN <= 1'b0;
                  memCke  <= 1'b0; // R2
                  doneFf  <= 1'b0;
                  cntFf   <= coldFf ? clampc(PWR_RST_CYCLES) : clampc(dmi_pkg::WARM_RST_CYC); // R1 R14
               end
            dmi_pkg::ST_RST:
               if (cntFf <= clampc(dmi_pkg::CKE_SETUP_CYC))
               begin
                  stateFf <= dmi_pkg::ST_CKELOW;
                  cntFf   <= clampc(dmi_pkg::CKE_SETUP_CYC);
               end
            dmi_pkg::ST_CKELOW:
               if (cntFf == '0)
               begin
                  memRstN <= 1'b1; // R2
                  stateFf <= dmi_pkg::ST_RSTEXIT;
                  cntFf   <= clampc(RST_EXIT_CYCLES); // R3
               end
            dmi_pkg::ST_RSTEXIT:
               if (cntFf == '0)
               begin
                  stateFf <= dmi_pkg::ST_CKEUP;
                  cntFf   <= clampc(CKSTB_CYC); // R4
               end
            dmi_pkg::ST_CKEUP:
            begin
               memCmd.csN <= 1'b0; // R4 NOP before CKE
               if (cntFf == '0 && clkRiseFf)
               begin
                  memCke  <= 1'b1; // R5
                  stateFf <= dmi_pkg::ST_XPR;
                  cntFf   <= clampc(XPR_CYC); // R8
               end
            end
            dmi_pkg::ST_XPR:
               if (cntFf == '0)
               begin
                  stateFf <= dmi_pkg::ST_MRS;
                  mrIdxFf <= 2'd0;
               end
            dmi_pkg::ST_MRS:
            begin
               memCmd  <= mrsCmd; // R15
               stateFf <= dmi_pkg::ST_MRSGAP;
               cntFf   <= (mrIdxFf == 2'd3) ? clampc(MOD_CYCLES) : clampc(MRD_CYCLES); // R17
            end
            dmi_pkg::ST_MRSGAP:
               if (cntFf == '0) // R12
               begin
                  mrIdxFf <= mrIdxFf + 2'd1;
                  if (mrIdxFf == 2'd3)
                  begin
                     stateFf <= remodeFf ? dmi_pkg::ST_READY : dmi_pkg::ST_ZQ;
                     doneFf  <= remodeFf; // Remode skips calibration
                  end
                  else
                     stateFf <= dmi_pkg::ST_MRS;
               end
            dmi_pkg::ST_ZQ:
            begin
               memCmd <= '{csN: 1'b0, rasN: 1'b1, casN: 1'b1, weN: 1'b0, bank: 3'h0,
                           addr: 13'h0_001 << dmi_pkg::ZQ_LONG_BIT};
               stateFf <= dmi_pkg::ST_CALWAIT;
               cntFf   <= clampc(CALW_CYC); // R13
            end
            dmi_pkg::ST_CALWAIT:
               if (cntFf == '0)
               begin
                  stateFf <= dmi_pkg::ST_READY;
                  doneFf  <= 1'b1;
               end
            dmi_pkg::ST_READY:
               if (startFf)
               begin
                  stateFf <= dmi_pkg::ST_RST;
                  memRstN <= 1'b0;
                  memCke  <= 1'b0;
                  doneFf  <= 1'b0;
                  cntFf   <= coldFf ? clampc(PWR_RST_CYCLES) : clampc(dmi_pkg::WARM_RST_CYC); // R14
               end
               else if (remodeFf)
               begin
                  // Idle device assumed: no bank traffic is issued by this block
                  stateFf <= dmi_pkg::ST_MRS; // R18
                  mrIdxFf <= 2'd0;
                  doneFf  <= 1'b0;
               end
            default:
            begin
               stateFf <= dmi_pkg::ST_IDLE;
               errFf   <= 1'b1;
            end
         endcase
      end
   end

   // Termination input held static from CKE high through initialization
   assign ckeHiSeen = memCke;
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         term_ctrl_in <= 1'b0;
      else if (!ckeHiSeen)
         term_ctrl_in <= termLvlFf; // R7
   end

   // Counts memory clock rises while CKE is held high, for the check below
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         tickCntFf <= 4'h0;
      else if (!memCke)
         tickCntFf <= 4'h0;
      else if (clkRiseFf && tickCntFf != 4'hF)
         tickCntFf <= tickCntFf + 4'h1;
   end

   chk_cke_hold_high: assert property (@(posedge ref_clk) disable iff (!arst_n) // R5
      (memCke && stateFf != dmi_pkg::ST_READY && !startFf) |=> memCke)
      else $error("clock enable dropped during initialization");
   chk_rst_cke_low: assert property (@(posedge ref_clk) disable iff (!arst_n) // R2
      $rose(memRstN) |-> !memCke && !$past(memCke))
      else $error("clock enable not low before reset release");
   chk_mrs_all_low: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
      (stateFf == dmi_pkg::ST_MRSGAP && $past(stateFf) == dmi_pkg::ST_MRS) |->
      (memCmd[19:16] == dmi_pkg::CMD_MRS))
      else $error("mode set strobes not all low");
   chk_first_mr2: assert property (@(posedge ref_clk) disable iff (!arst_n) // R9
      ($past(stateFf) == dmi_pkg::ST_XPR && stateFf == dmi_pkg::ST_MRS) |=>
      memCmd.bank == dmi_pkg::BA_MR2)
      else $error("first mode set not register two");
   chk_dll_reset: assert property (@(posedge ref_clk) disable iff (!arst_n) // R11
      (memCmd[19:16] == dmi_pkg::CMD_MRS && memCmd.bank == dmi_pkg::BA_MR0) |->
      memCmd.addr[dmi_pkg::MR0_DLL_RST] && !memCmd.addr[dmi_pkg::MR0_TEST])
      else $error("register zero missing DLL reset or test bit set");
   chk_gap_nop: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
      (stateFf == dmi_pkg::ST_MRSGAP && $past(stateFf) == dmi_pkg::ST_MRSGAP) |->
      memCmd.csN)
      else $error("command issued inside mode set gap");
   chk_term_static: assert property (@(posedge ref_clk) disable iff (!arst_n) // R7
      (memCke && $past(memCke)) |-> $stable(term_ctrl_in))
      else $error("termination input moved during init");
   chk_cke_setup: assert property (@(posedge ref_clk) disable iff (!arst_n) // R8
      $rose(memCke) |-> ##1 (memCmd.csN [*8]))
      else $error("command too soon after clock enable");
   chk_dll_en: assert property (@(posedge ref_clk) disable iff (!arst_n) // R11
      (memCmd[19:16] == dmi_pkg::CMD_MRS && memCmd.bank == dmi_pkg::BA_MR1) |->
      !memCmd.addr[dmi_pkg::MR1_DLL_DIS])
      else $error("DLL not enabled in register one");
   chk_xpr_ticks: assert property (@(posedge ref_clk) disable iff (!arst_n) // R8
      ($past(stateFf) == dmi_pkg::ST_XPR && stateFf == dmi_pkg::ST_MRS) |-> tickCntFf >= 4'h5)
      else $error("mode set before five clock periods");
endmodule

// >>> logic/dmi_pkg.sv
// Package for the DRAM initialization controller: constants, commands, carriers
// What the document requires
// R1: Hold reset low at least 200us after power is stable.
// R2: Drive clock-enable low at least 10ns before reset release.
// R3: Wait 500us after reset release before raising clock-enable.
// R4: Run clock at least max(10ns, 5 periods) and register NOP before clock-enable.
// R5: Keep clock-enable high continuously until initialization ends.
// R6: Device keeps termination high impedance until clock-enable registered high.
// R7: Hold termination control static from clock-enable high until init completes.
// R8: Wait reset exit time after clock-enable before first mode register set.
// R9: Program mode registers 2, 3, 1, 0 then long calibration.
// R10: Mode set drives all command strobes low; bank bits select register.
// R11: DLL enable is A0 low in register 1; DLL reset A8 high in register 0.
// R12: Only NOP or deselect between mode sets and long calibration.
// R13: After long calibration wait DLL lock and calibration time.
// R14: Warm reset holds reset at least 100ns then repeats the sequence.
// R15: Every mode register written in full after reset.
// R16: Each mode set drives every address field of the register.
// R17: Space mode sets by cycle time; wait update delay before other commands.
// R18: Mode rewrite in normal operation only when device idle.
// R19: Write recovery field at least write recovery time over clock period.
// R20: Column latency whole cycles from register zero bits A2, A4 to A6.
// R21: Register zero bit A7 written zero for normal operation.
// R22: Activate selects bank and row; reads use A10 and A12.
// R23: Device clears DLL reset bit itself after the reset.
// R24: Every wait timed by a counter loaded from a configurable value. Warm reset and CKE setup waits use fixed package values.
package dmi_pkg;
   localparam int CLK_PERIOD_PS   = 40000;
   localparam int PWR_RST_US      = 200;
   localparam int WARM_RST_NS     = 100;
   localparam int CKE_SETUP_NS    = 10;
   localparam int RST_EXIT_US     = 500;
   localparam int CLK_STABLE_NS   = 10;
   // Cycle counts, least times rounded up
   localparam int PWR_RST_CYC   = (PWR_RST_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WARM_RST_CYC  = (WARM_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CKE_SETUP_CYC = (CKE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RST_EXIT_CYC  = (RST_EXIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CLK_STB_NS_CYC = (CLK_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CLK_STB_TCK   = 5;
   localparam int XPR_TCK_MIN   = 5;
   // Register offsets of the controller's own APB map
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MR0    = 8'h08;
   localparam logic [7:0] OFF_MR1    = 8'h0C;
   localparam logic [7:0] OFF_MR2    = 8'h10;
   localparam logic [7:0] OFF_MR3    = 8'h14;
   localparam logic [7:0] OFF_WAIT   = 8'h18;
   // Control bits
   localparam int CTRL_START   = 0;
   localparam int CTRL_TERMLVL = 1;
   localparam int CTRL_COLD    = 2;
   localparam int CTRL_REMODE  = 3;
   localparam int CTRL_RESEL_LO = 4;
   // Mode register bit positions
   localparam int MR1_DLL_DIS = 0;
   localparam int MR0_DLL_RST = 8;
   localparam int MR0_TEST    = 7;
   // Mode register reset values
   localparam logic [12:0] MR0_RST = 13'h0_520;
   localparam logic [12:0] MR1_RST = 13'h0_000;
   localparam logic [12:0] MR2_RST = 13'h0_000;
   localparam logic [12:0] MR3_RST = 13'h0_000;
   localparam logic [7:0]  WAIT_RST = 8'h0_4;
   // Bank selects for the four registers
   localparam logic [2:0] BA_MR0 = 3'h0;
   localparam logic [2:0] BA_MR1 = 3'h1;
   localparam logic [2:0] BA_MR2 = 3'h2;
   localparam logic [2:0] BA_MR3 = 3'h3;
   // Command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DES = 4'hF;
   localparam logic [3:0] CMD_ZQL = 4'h6;
   localparam int ZQ_LONG_BIT = 10;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_RST     = 4'b0001,
      ST_CKELOW  = 4'b0010,
      ST_RSTEXIT = 4'b0011,
      ST_CKEUP   = 4'b0100,
      ST_XPR     = 4'b0101,
      ST_MRS     = 4'b0110,
      ST_MRSGAP  = 4'b0111,
      ST_ZQ      = 4'b1000,
      ST_CALWAIT = 4'b1001,
      ST_READY   = 4'b1010
   } dmi_state_e;

   // Command pins that travel together
   typedef struct packed {
      logic        csN;
      logic        rasN;
      logic        casN;
      logic        weN;
      logic [2:0]  bank;
      logic [12:0] addr;
   } dmi_cmd_s;
endpackage
